// file: src/isc_pkg.sv
// constants and carriers for the instruction sequencing core
// assumes one core clock and an avalon-mm register master
// Behaviour
// RULE_01 - swap endian only with reverse bit in user
// RULE_02 - load-linked sets the reservation flag
// RULE_03 - store-conditional tests then clears reservation
// RULE_04 - conflicting store elsewhere clears reservation
// RULE_05 - exception return clears the reservation
// RULE_06 - pc holds the executing instruction address
// RULE_07 - pc advances 2 compressed, else 4
// RULE_08 - branch target loads during delay slot
// RULE_09 - deferred result lands with next instruction
// RULE_10 - updates of one instruction keep order
// RULE_11 - fpr width bit selects 32 or 64
// RULE_12 - delay flag only for real delay slots
// RULE_13 - exception signalled at once, rest abandoned
// RULE_14 - four coprocessor slots share core control
// RULE_15 - system coprocessor always present
// RULE_16 - system coprocessor moves and functions
// RULE_17 - cpu endian is memory endian xor swap
// RULE_18 - memory endian fixed at chip reset
// RULE_19 - user mode needs ksu 10, no exl/erl/dm
// RULE_20 - reset clears the reservation flag
package isc_pkg;
    localparam logic [3:0] A_STATUS = 4'h0;
    localparam logic [3:0] A_PC = 4'h4;
    localparam logic [3:0] A_FLAGS = 4'h8;
    localparam logic [3:0] A_EXC = 4'hc;
    localparam logic [1:0] KSU_USER = 2'h2;
    localparam logic [6:0] STATUS_RST = 7'h20;
    localparam logic [31:0] PC_RST = 32'h0;
    localparam logic [31:0] EXC_VECTOR = 32'h80;
    localparam logic [31:0] INC_SHORT = 32'h2;
    localparam logic [31:0] INC_WORD = 32'h4;
    localparam logic [1:0] SYSTEM_COPROC_OPCODE_MT = 2'h1;
    localparam logic [1:0] SYSTEM_COPROC_OPCODE_MF = 2'h2;
    localparam logic [1:0] SYSTEM_COPROC_OPCODE_ERET = 2'h3;
    localparam logic [1:0] COP_SYS = 2'h0;
    localparam int NUM_COP = 4;
    localparam logic [1:0] STRAP_EDGE = 2'h2;
    localparam logic [4:0] EXC_COP_UNUSABLE = 5'h1;

    typedef struct packed {
        logic dm;
        logic error_level_bit;
        logic exception_level_bit;
        logic [1:0] privilege_level_field;
        logic fr;
        logic re;
    } isc_status_type;

    typedef struct packed {
        logic compressed;
        logic br_taken;
        logic [31:0] br_target;
        logic ll;
        logic sc;
        logic store;
        logic defer;
        logic wr_en;
        logic [4:0] wr_idx;
        logic [31:0] wr_data;
        logic cop_en;
        logic [1:0] cop_num;
        logic [1:0] system_coproc_opcode_op;
        logic exc_en;
        logic [4:0] exc_code;
        logic [31:0] exc_arg;
    } isc_instr_type;

    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [31:0] data;
    } isc_wb_type;

    typedef struct packed {
        logic valid;
        logic [4:0] code;
        logic [31:0] arg;
        logic [31:0] epc;
    } isc_exc_type;
endpackage

// file: src/isc_core.sv
// instruction sequencing core: pc, delay slot, reservation, modes
// assumes instructions arrive with valid/ready on clk, strap async
`timescale 1ns/1ps
module isc_core
    import isc_pkg::*;
#(
    parameter logic [NUM_COP-1:0] COP_PRESENT = 4'h1
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // instruction stream
    input wire logic instr_valid,
    input wire isc_instr_type instr,
    output logic instr_ready,
    input wire logic store_conflict,
    // strap pin
    input wire logic mem_big_endian_pin,
    // state
    output logic [31:0] pc,
    output logic in_delay_slot_flag,
    output logic link_reservation_flag,
    output logic endian_swap_active,
    output logic cpu_big_endian,
    output logic fpr_narrow_mode,
    output logic mem_big_endian,
    // results
    output isc_wb_type wb_now,
    output isc_wb_type wb_late,
    output logic store_commit,
    output logic sc_success,
    output logic cop_issue_valid,
    output logic [1:0] cop_issue_num,
    output isc_exc_type exc_out
);
    function automatic logic user_mode(input isc_status_type s);
        user_mode = (s.privilege_level_field == KSU_USER) & ~s.exception_level_bit & ~s.error_level_bit & ~s.dm;
    endfunction

    isc_status_type status;
    logic br_pend;
    logic [31:0] br_tgt;
    isc_wb_type late_q;
    logic rd_ack;
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;

    // system slot forced present whatever the parameter says
    wire [NUM_COP-1:0] cop_present = COP_PRESENT | 4'h1; // [RULE_14]
    wire step = instr_valid & instr_ready;
    wire cop_bad = instr.cop_en & ~cop_present[instr.cop_num]; // [RULE_15]
    wire take_exc = instr.exc_en | cop_bad;
    wire [4:0] exc_code = instr.exc_en ? instr.exc_code
                                       : EXC_COP_UNUSABLE;
    // an exception abandons every other effect [RULE_13]
    wire do_ok = step & ~take_exc;
    wire system_coproc_opcode_hit = do_ok & instr.cop_en & (instr.cop_num == COP_SYS);
    wire do_mt = system_coproc_opcode_hit & (instr.system_coproc_opcode_op == SYSTEM_COPROC_OPCODE_MT); // [RULE_16]
    wire do_mf = system_coproc_opcode_hit & (instr.system_coproc_opcode_op == SYSTEM_COPROC_OPCODE_MF); // [RULE_16]
    wire do_eret = system_coproc_opcode_hit & (instr.system_coproc_opcode_op == SYSTEM_COPROC_OPCODE_ERET);
    wire do_ll = do_ok & instr.ll;
    wire do_sc = do_ok & instr.sc;
    wire [31:0] pc_inc = instr.compressed ? INC_SHORT : INC_WORD;

    // [RULE_06] [RULE_07] [RULE_08]
    wire [31:0] next_pc = take_exc ? EXC_VECTOR :
                          br_pend ? br_tgt : pc + pc_inc;
    // set beats every clear in the same cycle [RULE_02] [RULE_04]
    wire next_ll = do_ll ? 1'b1 :
                   (do_sc | do_eret | store_conflict) ? 1'b0 :
                   link_reservation_flag; // [RULE_03] [RULE_05]

    // status: bus write, then system-coprocessor move, then
    // exception entry or return, last one wins [RULE_10]
    wire bus_wr_status = avs_write & (avs_address == A_STATUS);
    isc_status_type st_a;
    isc_status_type st_b;
    isc_status_type next_status;
    assign st_a = bus_wr_status ? isc_status_type'(avs_writedata[6:0])
                                : status;
    assign st_b = do_mt ? isc_status_type'(instr.wr_data[6:0]) : st_a;
    always_comb begin
        next_status = st_b;
        if (step & take_exc) begin
            next_status.exception_level_bit = 1'b1;
        end else if (do_eret) begin
            next_status.exception_level_bit = 1'b0;
            next_status.error_level_bit = 1'b0;
        end
    end

    // [RULE_01] [RULE_19]
    assign endian_swap_active = status.re & user_mode(status);
    assign cpu_big_endian = mem_big_endian ^ endian_swap_active; // [RULE_17]
    assign fpr_narrow_mode = ~status.fr; // [RULE_11]
    assign instr_ready = ~exc_out.valid;
    assign in_delay_slot_flag = br_pend; // [RULE_12]
    assign avs_waitrequest = avs_read & ~rd_ack;

    wire [31:0] rd_mux =
        (avs_address == A_STATUS) ? {25'h0, status} :
        (avs_address == A_PC) ? pc :
        (avs_address == A_FLAGS) ? {26'h0, mem_big_endian,
            fpr_narrow_mode, cpu_big_endian, endian_swap_active,
            in_delay_slot_flag, link_reservation_flag} :
        (avs_address == A_EXC) ? {27'h0, exc_out.code} : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ack <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            rd_ack <= avs_read & ~rd_ack;
            if (avs_read & ~rd_ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // strap caught only after release, through two flops [RULE_18]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            mem_big_endian <= 1'b0;
        end else begin
            strap_s1 <= mem_big_endian_pin;
            strap_s2 <= strap_s1;
            if (!strap_done) begin
                strap_cnt <= strap_cnt + 2'h1;
                if (strap_cnt == STRAP_EDGE) begin
                    mem_big_endian <= strap_s2;
                    strap_done <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status <= STATUS_RST;
            pc <= PC_RST;
            link_reservation_flag <= 1'b0; // [RULE_20]
        end else begin
            status <= next_status;
            link_reservation_flag <= next_ll;
            if (step) begin
                pc <= next_pc;
            end
        end
    end

    // branch target waits one instruction for the delay slot
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            br_pend <= 1'b0;
            br_tgt <= 32'h0;
        end else if (step) begin
            br_pend <= do_ok & instr.br_taken; // [RULE_08] [RULE_12]
            br_tgt <= instr.br_target;
        end
    end

    // deferred result is held and leaves with the next step [RULE_09]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            late_q <= '0;
            wb_late <= '0;
        end else begin
            wb_late.valid <= step & late_q.valid;
            if (step) begin
                wb_late.idx <= late_q.idx;
                wb_late.data <= late_q.data;
                late_q.valid <= do_ok & instr.wr_en & instr.defer;
                late_q.idx <= instr.wr_idx;
                late_q.data <= instr.wr_data;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_now <= '0;
            store_commit <= 1'b0;
            sc_success <= 1'b0;
            cop_issue_valid <= 1'b0;
            cop_issue_num <= 2'h0;
            exc_out <= '0;
        end else begin
            wb_now.valid <= do_mf |
                (do_ok & instr.wr_en & ~instr.defer);
            wb_now.idx <= instr.wr_idx;
            wb_now.data <= do_mf ? {25'h0, status} : instr.wr_data;
            // conditional store goes only with a live reservation
            store_commit <= do_ok & (instr.sc ? link_reservation_flag
                                              : instr.store); // [RULE_03]
            sc_success <= do_sc & link_reservation_flag; // [RULE_03]
            // other slots run off the core's own issue [RULE_14]
            cop_issue_valid <= do_ok & instr.cop_en &
                               (instr.cop_num != COP_SYS);
            cop_issue_num <= instr.cop_num;
            exc_out.valid <= step & take_exc; // [RULE_13]
            if (step & take_exc) begin
                exc_out.code <= exc_code;
                exc_out.arg <= instr.exc_arg;
                exc_out.epc <= pc;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_ll;
        do_ll;
    endsequence
    sequence s_taken;
        do_ok & instr.br_taken;
    endsequence
    sequence s_defer;
        do_ok & instr.wr_en & instr.defer;
    endsequence

    property p_ll_set;
        s_ll |=> link_reservation_flag;
    endproperty
    a_ll_set: assert property (p_ll_set) // [RULE_02]
        else $error("reservation not set by load-linked");

    property p_sc;
        do_sc & ~do_ll |=> !link_reservation_flag &&
            sc_success == $past(link_reservation_flag) &&
            store_commit == sc_success;
    endproperty
    a_sc: assert property (p_sc) // [RULE_03]
        else $error("store-conditional result or clear wrong");

    property p_conflict;
        store_conflict & ~do_ll |=> !link_reservation_flag;
    endproperty
    a_conflict: assert property (p_conflict) // [RULE_04]
        else $error("conflicting store left reservation");

    property p_eret;
        do_eret |=> !link_reservation_flag && !status.exception_level_bit;
    endproperty
    a_eret: assert property (p_eret) // [RULE_05]
        else $error("exception return kept reservation");

    property p_inc;
        do_ok & ~br_pend |=> pc == $past(pc) +
            ($past(instr.compressed) ? INC_SHORT : INC_WORD);
    endproperty
    a_inc: assert property (p_inc) // [RULE_07]
        else $error("pc increment wrong");

    // the delay slot itself steps: target lands, flag drops
    property p_branch;
        br_pend & do_ok & ~instr.br_taken |=>
            pc == $past(br_tgt) && !in_delay_slot_flag;
    endproperty
    a_branch: assert property (p_branch) // [RULE_08]
        else $error("branch target not taken after delay slot");

    property p_slot;
        s_taken |=> in_delay_slot_flag;
    endproperty
    a_slot: assert property (p_slot) // [RULE_12]
        else $error("delay slot flag missing");

    property p_exc;
        step & take_exc |=> exc_out.valid && pc == EXC_VECTOR &&
            !wb_now.valid && !store_commit && !in_delay_slot_flag;
    endproperty
    a_exc: assert property (p_exc) // [RULE_13]
        else $error("exception did not abandon instruction");

    property p_defer;
        s_defer |=> !wb_now.valid && late_q.valid;
    endproperty
    a_defer: assert property (p_defer) // [RULE_09]
        else $error("deferred write out of time");

    // held result leaves with whatever steps next
    property p_late;
        step & late_q.valid |=> wb_late.valid &&
            wb_late.data == $past(late_q.data);
    endproperty
    a_late: assert property (p_late) // [RULE_09]
        else $error("deferred write not sent with next step");

    property p_sys;
        step & instr.cop_en & (instr.cop_num == COP_SYS) &
            ~instr.exc_en |=> !exc_out.valid;
    endproperty
    a_sys: assert property (p_sys) // [RULE_15]
        else $error("system coprocessor refused");

    property p_swap;
        !user_mode(status) |-> !endian_swap_active &&
            cpu_big_endian == mem_big_endian;
    endproperty
    a_swap: assert property (p_swap) // [RULE_01] [RULE_17]
        else $error("endian swap outside user mode");
endmodule

// file: tb/isc_cop_model.sv
// coprocessor slot model: sums the slot numbers issued by the core
// assumes issue pulses arrive on the core clock
`timescale 1ns/1ps
module isc_cop_model
    import isc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // issue from core
    input wire logic cop_issue_valid,
    input wire logic [1:0] cop_issue_num,
    // seen issues
    output logic [7:0] issued
);
    // slot works only on what the core issues
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            issued <= 8'h0;
        end else if (cop_issue_valid) begin
            issued <= issued + {6'h0, cop_issue_num};
        end
    end
endmodule

// file: tb/testbench.sv
// self-checking bench for the instruction sequencing core
// assumes 100 MHz clk, async active-low nrst
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
    import isc_pkg::*;
    typedef struct {
        isc_instr_type i;
        logic [31:0] dpc;
        logic ll;
        logic scs;
        logic late;
    } isc_row_type;
    logic clk = 0;
    logic nrst = 0;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, instr_valid, instr_ready;
    logic [31:0] avs_writedata, avs_readdata, pc, p0, rd;
    logic store_conflict, pin, dly, llb, swp, cbe, fnm, mbe, scm, scs, cv;
    logic [1:0] cn;
    logic [7:0] issued;
    isc_instr_type instr, x;
    isc_wb_type wb_now, wb_late;
    isc_exc_type exc_out;
    isc_row_type rows[7];
    int err_total = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    isc_core #(.COP_PRESENT(4'h3)) u_dut (.clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .instr_valid, .instr, .instr_ready,
        .store_conflict, .mem_big_endian_pin(pin), .pc,
        .in_delay_slot_flag(dly), .link_reservation_flag(llb),
        .endian_swap_active(swp), .cpu_big_endian(cbe),
        .fpr_narrow_mode(fnm), .mem_big_endian(mbe), .wb_now, .wb_late,
        .store_commit(scm), .sc_success(scs), .cop_issue_valid(cv),
        .cop_issue_num(cn), .exc_out);
    isc_cop_model u_cop (.clk, .nrst, .cop_issue_valid(cv),
        .cop_issue_num(cn), .issued);
    task automatic complete_run();
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // holds the request until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a,
            input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge clk);
    endtask
    task automatic step(input isc_instr_type i);
        @(posedge clk);
        instr <= i;
        instr_valid <= 1'b1;
        do @(posedge clk); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        @(negedge clk);
    endtask
    function automatic isc_instr_type mk(input logic c, l, s, d);
        isc_instr_type r;
        r = '0;
        r.compressed = c;
        r.ll = l;
        r.sc = s;
        r.defer = d;
        r.wr_en = d;
        r.wr_idx = 5'h3;
        r.wr_data = 32'h5a;
        return r;
    endfunction
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {instr_valid, store_conflict} = '0;
        instr = '0;
        pin = 1'b1;
        rows = '{'{mk(0, 0, 0, 0), 4, 0, 0, 0}, '{mk(1, 0, 0, 0), 2, 0, 0, 0},
            '{mk(0, 1, 0, 0), 4, 1, 0, 0}, '{mk(0, 0, 1, 0), 4, 0, 1, 0},
            '{mk(0, 0, 1, 0), 4, 0, 0, 0}, '{mk(0, 0, 0, 1), 4, 0, 0, 0},
            '{mk(1, 0, 0, 0), 2, 0, 0, 1}};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("pc", PC_RST, pc)
        `CHK("link_reservation_flag", 1'b0, llb)
        bus(0, A_STATUS, 0);
        `CHK("status", {25'h0, STATUS_RST}, rd)
        `CHK("mem_big", 1'b1, mbe)
        foreach (rows[k]) begin
            p0 = pc;
            step(rows[k].i);
            `CHK("pc_step", p0 + rows[k].dpc, pc)
            `CHK("link_reservation_flag", rows[k].ll, llb)
            `CHK("sc_ok", rows[k].scs, scs)
            `CHK("commit", rows[k].scs, scm)
            `CHK("late", rows[k].late, wb_late.valid)
        end
        step(mk(0, 1, 0, 0));
        @(posedge clk);
        store_conflict <= 1'b1;
        @(posedge clk);
        store_conflict <= 1'b0;
        @(negedge clk);
        `CHK("conflict", 1'b0, llb)
        step(mk(0, 1, 0, 0));
        x = '0;
        x.cop_en = 1'b1;
        x.system_coproc_opcode_op = SYSTEM_COPROC_OPCODE_ERET;
        step(x);
        `CHK("eret", 1'b0, llb)
        x = '0;
        p0 = pc;
        x.br_taken = 1'b1;
        x.br_target = 32'h100;
        step(x);
        `CHK("slot_pc", p0 + INC_WORD, pc)
        `CHK("slot", 1'b1, dly)
        step(mk(0, 0, 0, 0));
        `CHK("target", 32'h100, pc)
        `CHK("slot", 1'b0, dly)
        bus(1, A_STATUS, 32'h0b);
        `CHK("swap", 1'b1, swp)
        `CHK("cpu_big", 1'b0, cbe)
        `CHK("fpr", 1'b0, fnm)
        bus(1, A_STATUS, 32'h4b);
        `CHK("swap_dm", 1'b0, swp)
        `CHK("cpu_big", 1'b1, cbe)
        bus(0, A_FLAGS, 0);
        `CHK("flags", 32'h28, rd)
        bus(0, 4'h2, 0);
        `CHK("unmapped", 32'h0, rd)
        step(mk(0, 1, 0, 0));
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        `CHK("link_reservation_flag_rst", 1'b0, llb)
        `CHK("pc_rst", PC_RST, pc)
        `CHK("fpr_rst", 1'b1, fnm)
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        x = '0;
        x.cop_en = 1'b1;
        x.system_coproc_opcode_op = SYSTEM_COPROC_OPCODE_MT;
        x.wr_data = 32'h02;
        step(x);
        `CHK("mt_fpr", 1'b0, fnm)
        x.system_coproc_opcode_op = SYSTEM_COPROC_OPCODE_MF;
        x.wr_data = 32'h0;
        x.wr_en = 1'b1;
        x.wr_idx = 5'h5;
        step(x);
        `CHK("mf", 1'b1, wb_now.valid)
        `CHK("mf_data", 32'h02, wb_now.data)
        x.cop_num = 2'h1;
        x.wr_en = 1'b0;
        step(x);
        @(negedge clk);
        `CHK("issued", 8'h1, issued)
        x.cop_num = 2'h2;
        x.wr_en = 1'b1;
        p0 = pc;
        step(x);
        `CHK("epc", p0, exc_out.epc)
        `CHK("exc", 1'b1, exc_out.valid)
        `CHK("code", EXC_COP_UNUSABLE, exc_out.code)
        `CHK("vec", EXC_VECTOR, pc)
        `CHK("drop", 1'b0, wb_now.valid)
        complete_run();
    end
endmodule
